// File: design/stu_uart.sv
// shifter/timer uart: tx shifter+timer 0, rx shifter+timer 1, axi4-lite registers
//
// How it works
// - tx shifter drives tx pin high-active, changes output on shift clock rise
// - writing tx buffer low byte starts an 8-bit frame
// - frames carry one start bit 0 and exactly one stop bit 1
// - no parity bit generated or checked
// - tx empty flag set when buffer moves into shifter, cleared by buffer write
// - timer 0 enabled by tx empty flag low with the shifter idle (active-low trigger)
// - each timer has 8-bit baud divider and 8-bit edge counter
// - timers decrement every clock; toggling output is the shift clock
// - timer output starts at 1 on enable; timers never restart on a trigger mid-run, drive no pin
// - timer disables one bit period after counter reaches zero, shifting stops
// - start-bit period on enable, stop-bit period on disable
// - rx shifter samples rx pin on shift clock fall, output disabled
// - received byte lands in rx buffer bits 31:24
// - timer 1 enabled by rising edge on rx pin
// - tx and rx paths are fully independent
// - timer controls shifter load, store and shift
//
// Added by the designer: the AXI4-Lite register port and the address map.
module stu_uart
    import stu_pkg::*;
#(
    parameter int DATA_BITS = 8
) (
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    input  wire logic [7:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i,
    input  wire logic        rx_line_pin_i,
    output logic             tx_line_pin_o,
    output logic             tx_line_pin_oe_o
);
    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic        mod_en;
    logic        soft_rst;
    stu_cmp_t    tx_cmp;
    stu_cmp_t    rx_cmp;
    logic [7:0]  shift_buffer_tx;
    logic [31:0] shift_buffer_rx;
    logic        tx_empty;
    logic        rx_full;
    logic        aw_hold;
    logic        w_hold;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        do_write;
    logic        do_read;
    logic        tx_buf_wr;
    logic        rx_buf_rd;
    logic        lrst;
    logic        tx_load;
    logic        rx_store;
    assign lrst = rst_i || soft_rst || !mod_en;
    ////////////////////////////////////////////////////////////////////////////
    // axi write channel: address and data taken in either order
    assign s_axi_awready_o = !aw_hold && !s_axi_bvalid_o;
    assign s_axi_wready_o  = !w_hold && !s_axi_bvalid_o;
    assign do_write = aw_hold && w_hold && !s_axi_bvalid_o;
    assign tx_buf_wr = do_write && aw_addr == STU_OFS_TX_BUF && w_strb[0];
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            aw_hold <= 1'b0;
            w_hold  <= 1'b0;
            aw_addr <= 8'h00;
            w_data  <= 32'h0000_0000;
            w_strb  <= 4'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= STU_RESP_OKAY;
        end else begin
            if (s_axi_awvalid_i && s_axi_awready_o) begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end
            if (s_axi_wvalid_i && s_axi_wready_o) begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold  <= 1'b0;
                s_axi_bvalid_o <= 1'b1;
                case (aw_addr)
                    STU_OFS_CTRL, STU_OFS_TX_CMP, STU_OFS_RX_CMP, STU_OFS_TX_BUF:
                        s_axi_bresp_o <= STU_RESP_OKAY;
                    default: s_axi_bresp_o <= STU_RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid_o && s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end
    // control and compare registers; soft reset self-clears after one cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mod_en   <= STU_CTRL_RST[STU_CTRL_EN_BIT];
            soft_rst <= STU_CTRL_RST[STU_CTRL_SRST_BIT];
            tx_cmp   <= STU_CMP_RST;
            rx_cmp   <= STU_CMP_RST;
        end else begin
            soft_rst <= 1'b0;
            if (do_write && w_strb[0] && aw_addr == STU_OFS_CTRL) begin
                mod_en   <= w_data[STU_CTRL_EN_BIT];
                soft_rst <= w_data[STU_CTRL_SRST_BIT];
            end
            if (do_write && aw_addr == STU_OFS_TX_CMP) begin
                if (w_strb[0]) tx_cmp.half  <= w_data[7:0];
                if (w_strb[1]) tx_cmp.edges <= w_data[15:8];
            end
            if (do_write && aw_addr == STU_OFS_RX_CMP) begin
                if (w_strb[0]) rx_cmp.half  <= w_data[7:0];
                if (w_strb[1]) rx_cmp.edges <= w_data[15:8];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // axi read channel: one read outstanding, answer one cycle after address
    assign s_axi_arready_o = !s_axi_rvalid_o;
    assign do_read   = s_axi_arvalid_i && s_axi_arready_o;
    assign rx_buf_rd = do_read && s_axi_araddr_i == STU_OFS_RX_BUF;
    logic tx_busy;
    logic rx_busy;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0000_0000;
            s_axi_rresp_o  <= STU_RESP_OKAY;
        end else if (do_read) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o  <= STU_RESP_OKAY;
            case (s_axi_araddr_i)
                STU_OFS_CTRL:   s_axi_rdata_o <= {30'h0, soft_rst, mod_en};
                STU_OFS_STATUS: s_axi_rdata_o <= {28'h0, rx_busy, tx_busy, rx_full, tx_empty};
                STU_OFS_TX_CMP: s_axi_rdata_o <= {16'h0, tx_cmp};
                STU_OFS_RX_CMP: s_axi_rdata_o <= {16'h0, rx_cmp};
                STU_OFS_TX_BUF: s_axi_rdata_o <= {24'h0, shift_buffer_tx};
                STU_OFS_RX_BUF: s_axi_rdata_o <= shift_buffer_rx;
                default: begin
                    s_axi_rdata_o <= 32'h0000_0000;
                    s_axi_rresp_o <= STU_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // rx pin synchroniser: three flops, a change counts when stages 2 and 3 agree
    logic [2:0] rx_sync;
    logic       rx_level;
    logic       rx_rise;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_sync  <= 3'b111;
            rx_level <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], rx_line_pin_i};
            if (rx_sync[2] == rx_sync[1]) rx_level <= rx_sync[2];
        end
    end
    assign rx_rise = (rx_sync[2] == rx_sync[1]) && rx_sync[2] && !rx_level;
    ////////////////////////////////////////////////////////////////////////////
    // two identical timers, index 0 tx, index 1 rx; each toggles its shift clock
    logic [1:0] t_en;
    logic [1:0] t_out;
    logic [1:0] t_rise;
    logic [1:0] t_fall;
    logic [1:0] t_done;
    logic [1:0] trig;
    stu_cmp_t   cmp_sel [2];
    assign cmp_sel[0] = tx_cmp;
    assign cmp_sel[1] = rx_cmp;
    // flag low only starts the timer from an idle shifter, never during a stop bit
    assign trig[0]    = tx_load;
    assign trig[1]    = rx_rise;
    for (genvar i = 0; i < 2; i++) begin : g_timer
        logic [7:0] baud_cnt;
        logic [7:0] edge_cnt;
        logic       tick;
        logic       stop_ph;
        // low byte divides the clock, high byte counts shift edges
        assign tick = t_en[i] && baud_cnt == 8'h00;
        always_ff @(posedge ref_clk_i) begin
            if (lrst) begin
                t_en[i]   <= 1'b0;
                t_out[i]  <= 1'b1;
                baud_cnt  <= 8'h00;
                edge_cnt  <= 8'h00;
                stop_ph   <= 1'b0;
                t_done[i] <= 1'b0;
            end else begin
                t_done[i] <= 1'b0;
                if (!t_en[i]) begin
                    if (trig[i]) begin
                        t_en[i]  <= 1'b1;
                        t_out[i] <= 1'b1;
                        baud_cnt <= cmp_sel[i].half;
                        edge_cnt <= cmp_sel[i].edges;
                        stop_ph  <= 1'b0;
                    end
                end else if (tick) begin
                    baud_cnt <= cmp_sel[i].half;
                    t_out[i] <= !t_out[i];
                    // on compare, one more bit period of stop before disabling
                    if (edge_cnt != 8'h00) begin
                        edge_cnt <= edge_cnt - 8'h01;
                    end else if (!stop_ph) begin
                        stop_ph  <= 1'b1;
                        edge_cnt <= 8'h01;
                    end else begin
                        t_en[i]   <= 1'b0;
                        t_done[i] <= 1'b1;
                    end
                end else begin
                    baud_cnt <= baud_cnt - 8'h01;
                end
            end
        end
        assign t_rise[i] = tick && !t_out[i];
        assign t_fall[i] = tick && t_out[i] && edge_cnt != 8'h00 && !stop_ph;
    end
    ////////////////////////////////////////////////////////////////////////////
    // tx shifter: start bit on enable, data lsb first on rising shift clock,
    // then the stop bit, held through the timer's stop period; idles high.
    stu_tstate_t tx_st;
    logic [7:0]  tx_sh;
    logic [3:0]  tx_bits;
    logic        tx_pin;
    assign tx_load = t_en[0] == 1'b0 && !tx_empty && tx_st == STU_T_IDLE;
    always_ff @(posedge ref_clk_i) begin
        if (lrst) begin
            tx_st   <= STU_T_IDLE;
            tx_sh   <= 8'h00;
            tx_bits <= 4'h0;
            tx_pin  <= 1'b1;
        end else begin
            case (tx_st)
                STU_T_IDLE: if (tx_load) begin
                    tx_sh   <= shift_buffer_tx;
                    tx_bits <= 4'(DATA_BITS);
                    tx_pin  <= 1'b0;
                    tx_st   <= STU_T_RUN;
                end
                STU_T_RUN: if (t_rise[0]) begin
                    if (tx_bits == 4'h0) begin
                        tx_pin <= 1'b1;
                        tx_st  <= STU_T_STOP;
                    end else begin
                        tx_pin  <= tx_sh[0];
                        tx_sh   <= {1'b0, tx_sh[7:1]};
                        tx_bits <= tx_bits - 4'h1;
                    end
                end
                STU_T_STOP: if (!t_en[0]) tx_st <= STU_T_IDLE;
                default: tx_st <= STU_T_IDLE;
            endcase
        end
    end
    assign tx_line_pin_o    = tx_pin;
    assign tx_line_pin_oe_o = 1'b1;
    assign tx_busy          = tx_st != STU_T_IDLE;
    // tx empty flag: buffer write clears, load into shifter sets; load wins
    always_ff @(posedge ref_clk_i) begin
        if (lrst) begin
            tx_empty        <= 1'b1;
            shift_buffer_tx <= 8'h00;
        end else if (tx_load) begin
            tx_empty <= 1'b1;
        end else if (tx_buf_wr) begin
            tx_empty        <= 1'b0;
            shift_buffer_tx <= w_data[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // rx shifter: samples rx on falling shift clock, start bit then data, stores
    // the byte on timer disable; no output drive on the rx pin.
    logic [8:0] rx_sh;
    logic [3:0] rx_cnt;
    assign rx_store = t_done[1];
    always_ff @(posedge ref_clk_i) begin
        if (lrst) begin
            rx_sh  <= 9'h000;
            rx_cnt <= 4'h0;
        end else if (!t_en[1]) begin
            rx_cnt <= 4'h0;
        end else if (t_fall[1] && rx_cnt <= 4'(DATA_BITS)) begin
            rx_sh  <= {rx_level, rx_sh[8:1]};
            rx_cnt <= rx_cnt + 4'h1;
        end
    end
    assign rx_busy = t_en[1];
    // rx full flag: store sets, buffer read clears; store wins
    always_ff @(posedge ref_clk_i) begin
        if (lrst) begin
            rx_full         <= 1'b0;
            shift_buffer_rx <= 32'h0000_0000;
        end else if (rx_store) begin
            rx_full <= 1'b1;
            shift_buffer_rx[STU_RXBYTE_LSB +: 8] <= rx_sh[8:1];
        end else if (rx_buf_rd) begin
            rx_full <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // assertions
    property p_tx_idle_high;
        @(posedge ref_clk_i) disable iff (lrst) tx_st == STU_T_IDLE |-> tx_line_pin_o;
    endproperty
    a_tx_idle_high: assert property (p_tx_idle_high) else $error("tx not idle high");
    property p_start_low;
        @(posedge ref_clk_i) disable iff (lrst) tx_load |=> !tx_line_pin_o;
    endproperty
    a_start_low: assert property (p_start_low) else $error("no start bit");
    property p_wr_clears;
        @(posedge ref_clk_i) disable iff (lrst) tx_buf_wr && !tx_load |=> !tx_empty;
    endproperty
    a_wr_clears: assert property (p_wr_clears) else $error("write did not clear flag");
    property p_t0_enable;
        @(posedge ref_clk_i) disable iff (lrst)
            !t_en[0] && !tx_empty && tx_st == STU_T_IDLE |=> t_en[0];
    endproperty
    a_t0_enable: assert property (p_t0_enable) else $error("timer 0 not enabled");
    property p_init_out;
        @(posedge ref_clk_i) disable iff (lrst) $rose(t_en[1]) |-> t_out[1];
    endproperty
    a_init_out: assert property (p_init_out) else $error("initial output not 1");
    property p_t1_trig;
        @(posedge ref_clk_i) disable iff (lrst) $rose(t_en[1]) |-> $past(rx_rise);
    endproperty
    a_t1_trig: assert property (p_t1_trig) else $error("timer 1 without rx rise");
    property p_store_full;
        @(posedge ref_clk_i) disable iff (lrst) rx_store |=> rx_full;
    endproperty
    a_store_full: assert property (p_store_full) else $error("rx flag not set");
    property p_oe;
        @(posedge ref_clk_i) disable iff (rst_i) tx_line_pin_oe_o;
    endproperty
    a_oe: assert property (p_oe) else $error("tx pin not driven");
    property p_done_off;
        @(posedge ref_clk_i) disable iff (lrst) t_done[0] |-> !t_en[0];
    endproperty
    a_done_off: assert property (p_done_off) else $error("timer still on");
    c_tx_frame: cover property (@(posedge ref_clk_i) disable iff (lrst) tx_load ##[1:1000] t_done[0]);
    c_rx_store: cover property (@(posedge ref_clk_i) disable iff (lrst) rx_store);
    c_rx_read:  cover property (@(posedge ref_clk_i) disable iff (lrst) rx_full && rx_buf_rd);
endmodule

// File: design/stu_pkg.sv
// package: register map, reset values and carrier types for the shifter/timer uart
package stu_pkg;
    // register byte offsets
    localparam logic [7:0]  STU_OFS_CTRL     = 8'h00;
    localparam logic [7:0]  STU_OFS_STATUS   = 8'h04;
    localparam logic [7:0]  STU_OFS_TX_CMP   = 8'h08;
    localparam logic [7:0]  STU_OFS_RX_CMP   = 8'h0C;
    localparam logic [7:0]  STU_OFS_TX_BUF   = 8'h10;
    localparam logic [7:0]  STU_OFS_RX_BUF   = 8'h14;
    // field positions
    localparam int          STU_CTRL_EN_BIT  = 0;
    localparam int          STU_CTRL_SRST_BIT = 1;
    localparam int          STU_ST_TXE_BIT   = 0;
    localparam int          STU_ST_RXF_BIT   = 1;
    localparam int          STU_ST_TXBSY_BIT = 2;
    localparam int          STU_ST_RXBSY_BIT = 3;
    localparam int          STU_RXBYTE_LSB   = 24;
    // reset values
    localparam logic [15:0] STU_CMP_RST      = 16'h0000;
    localparam logic [31:0] STU_CTRL_RST     = 32'h0000_0000;
    // axi responses
    localparam logic [1:0]  STU_RESP_OKAY    = 2'h0;
    localparam logic [1:0]  STU_RESP_SLVERR  = 2'h2;
    // tx shifter states
    typedef enum logic [1:0] {STU_T_IDLE, STU_T_START, STU_T_RUN, STU_T_STOP} stu_tstate_t;
    // compare value layout: high byte edges, low byte half-baud
    typedef struct packed {
        logic [7:0] edges;
        logic [7:0] half;
    } stu_cmp_t;
endpackage

// File: dv/stu_peer.sv
// uart peer model: frames bytes onto the receive line, deframes the transmit line
module stu_peer #(
    parameter int BIT_CYC = 10
) (
    input  wire logic  clk_i,
    input  wire logic  tx_line_pin_i,
    output logic       rx_line_pin_o,
    output logic [9:0] frame_o,
    output logic       frame_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // the line idles high, as any uart peer leaves it
    initial begin
        rx_line_pin_o = 1'b1;
        frame_o = 10'h000;
        frame_valid_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // deframe: sample mid-bit so a bit period off by one cycle drifts into a neighbour
    always begin
        @(negedge tx_line_pin_i);
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            frame_o[i] <= tx_line_pin_i;
            if (i < 9) begin
                repeat (BIT_CYC) @(posedge clk_i);
            end
        end
        frame_valid_o <= 1'b1;
        @(posedge clk_i);
        frame_valid_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // send one frame; a short low pulse first gives the receive trigger its rising edge
    task automatic send(input logic [7:0] b);
        logic [9:0] fr;
        fr = {1'b1, b, 1'b0};
        @(posedge clk_i);
        rx_line_pin_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        rx_line_pin_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 10; i++) begin
            rx_line_pin_o <= fr[i];
            repeat (BIT_CYC) @(posedge clk_i);
        end
    endtask
endmodule

// File: dv/shifter_timer_uart_test.sv
// self-checking bench for the shifter/timer uart: axi4-lite master, peer, monitors
module shifter_timer_uart_test;
    timeunit 1ns;
    timeprecision 1ps;
    import stu_pkg::*;

    // half 4 gives a ten-cycle bit; edges 0x11 covers start plus eight data bits
    localparam logic [31:0] CMP  = 32'h0000_1104;
    localparam int          BITC = 10;

    logic        ref_clk_i, rst_i;
    logic [7:0]  awaddr, araddr, b;
    logic [31:0] wdata, rdata, got, seed;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp;
    logic        rx_line, tx_line, tx_oe, frame_valid;
    logic [9:0]  frame;
    logic [34:0] note;
    logic [34:0] rq[$];
    logic [1:0]  bq[$];
    logic [9:0]  tq[$];
    int          fails, n_compared;

    stu_uart #(.DATA_BITS(8)) stu_uart_i (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .rx_line_pin_i(rx_line),
        .tx_line_pin_o(tx_line), .tx_line_pin_oe_o(tx_oe));

    stu_peer #(.BIT_CYC(BITC)) stu_peer_i (
        .clk_i(ref_clk_i), .tx_line_pin_i(tx_line), .rx_line_pin_o(rx_line),
        .frame_o(frame), .frame_valid_o(frame_valid));

    ////////////////////////////////////////////////////////////////////////////////
    // clock, and a watchdog well beyond the thousand or so cycles the run needs
    always #5 ref_clk_i = ~ref_clk_i;
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        fails++;
        stop_test();
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite write; address and data released separately as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp);
        @(posedge ref_clk_i);
        bq.push_back(resp);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge ref_clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (!bvalid) fails++;  // no response within the limit
        bready <= 1'b0;
    endtask

    // axi4-lite read; chk low marks a poll whose data is not compared
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp,
                      input logic chk, output logic [31:0] val);
        @(posedge ref_clk_i);
        rq.push_back({chk, resp, d});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 100; n++) begin
            @(posedge ref_clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        val = rdata;
        if (!rvalid) fails++;  // no response within the limit
        rready <= 1'b0;
    endtask

    task automatic poll(input int idx, input logic val);
        for (int n = 0; n < 300; n++) begin
            rd(STU_OFS_STATUS, 32'h0, STU_RESP_OKAY, 1'b0, got);
            if (got[idx] === val) break;
        end
        if (got[idx] !== val) fails++;  // flag never reached the awaited level
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // monitor: each answer seen on the ports is matched against the oldest note
    always @(posedge ref_clk_i) begin
        if (rvalid && rready && rq.size() > 0) begin
            note = rq.pop_front();
            if (note[34]) begin
                check(rdata, note[31:0]);
                check({30'h0, rresp}, {30'h0, note[33:32]});
            end
        end
        if (bvalid && bready) check({30'h0, bresp}, {30'h0, bq.pop_front()});
        if (frame_valid) check({22'h0, frame}, {22'h0, tq.pop_front()});
    end

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: registers, back-to-back transmit, receive alongside transmit
    initial begin
        ref_clk_i = 1'b0;
        rst_i = 1'b1;
        {awaddr, araddr, wdata, wstrb} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        seed = 32'hdc1d;
        fails = 0;
        n_compared = 0;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(STU_OFS_STATUS, 32'h0000_0001, STU_RESP_OKAY, 1'b1, got);
        rd(STU_OFS_CTRL, STU_CTRL_RST, STU_RESP_OKAY, 1'b1, got);
        rd(8'h18, 32'h0, STU_RESP_SLVERR, 1'b1, got);
        wr(8'h1C, 32'hFFFF_FFFF, STU_RESP_SLVERR);
        wr(STU_OFS_CTRL, 32'h0000_0001, STU_RESP_OKAY);
        wr(STU_OFS_CTRL, 32'h0000_0003, STU_RESP_OKAY);
        wr(STU_OFS_CTRL, 32'h0000_0001, STU_RESP_OKAY);
        wr(STU_OFS_TX_CMP, CMP, STU_RESP_OKAY);
        wr(STU_OFS_RX_CMP, CMP, STU_RESP_OKAY);
        rd(STU_OFS_TX_CMP, CMP, STU_RESP_OKAY, 1'b1, got);
        // boundary bytes first, then random; each written as soon as the buffer empties
        for (int k = 0; k < 5; k++) begin
            b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : seed[7:0];
            seed = lfsr_next(seed);
            tq.push_back({1'b1, b, 1'b0});
            wr(STU_OFS_TX_BUF, {24'h0, b}, STU_RESP_OKAY);
            poll(STU_ST_TXE_BIT, 1'b1);
        end
        for (int n = 0; n < 3000 && tq.size() > 0; n++) @(posedge ref_clk_i);
        repeat (3 * BITC) @(posedge ref_clk_i);
        check({30'h0, tx_oe, tx_line}, 32'h0000_0003);
        rd(STU_OFS_STATUS, 32'h0000_0001, STU_RESP_OKAY, 1'b1, got);
        // receive while the transmitter runs the inverse byte
        for (int k = 0; k < 3; k++) begin
            b = (k == 0) ? 8'h80 : seed[7:0];
            seed = lfsr_next(seed);
            tq.push_back({1'b1, ~b, 1'b0});
            fork
                stu_peer_i.send(b);
                wr(STU_OFS_TX_BUF, {24'h0, ~b}, STU_RESP_OKAY);
            join
            poll(STU_ST_RXF_BIT, 1'b1);
            rd(STU_OFS_RX_BUF, {b, 24'h0}, STU_RESP_OKAY, 1'b1, got);
            rd(STU_OFS_STATUS, 32'h0, STU_RESP_OKAY, 1'b0, got);
            check({31'h0, got[STU_ST_RXF_BIT]}, 32'h0);
        end
        for (int n = 0; n < 3000 && tq.size() > 0; n++) @(posedge ref_clk_i);
        check(tq.size(), 32'h0);
        stop_test();
    end
endmodule
